// ===== design/cbp_pkg.sv
// Purpose: Shared constants for the contactless block protocol controller
// Assumes: Single core clock, blocks delivered already deframed and CRC-checked
// Notes:   Block control byte codings follow the common proximity block layout
package cbp_pkg;
  // Block type field, control byte bits 7:6
  localparam logic [1:0] PCB_TYPE_I = 2'h0;  // Information block
  localparam logic [1:0] PCB_TYPE_R = 2'h2;  // Receive-ready block
  localparam logic [1:0] PCB_TYPE_S = 2'h3;  // Supervisory block
  // Field positions inside the control byte
  localparam int PCB_BN_BIT    = 0;   // Block number
  localparam int PCB_CHAIN_BIT = 4;   // Chaining indication
  localparam int PCB_NAK_BIT   = 4;   // R-block: NAK when set
  localparam int PCB_CID_BIT   = 3;   // Card identifier follows
  localparam int PCB_NAD_BIT   = 2;   // Node address follows
  // Complete control bytes sent by the transponder (bn is OR-ed into the I and R bytes)
  localparam logic [7:0] PCB_I_BASE    = 8'h02;  // I-block, no chaining
  localparam logic [7:0] PCB_R_ACK     = 8'ha2;  // R(ACK)
  localparam logic [7:0] PCB_S_DESEL   = 8'hc2;  // S(DESELECT)
  localparam logic [1:0] S_KIND_DESEL  = 2'h0;   // Bits 5:4 of DESELECT
  // Block number after activation
  localparam logic       BN_RESET      = 1'h1;
  // Upper-layer command checks
  localparam logic [7:0] CLA_ONLY      = 8'h00;  // Only supported class
  localparam logic [7:0] SW1_BAD_CLA   = 8'h6e;  // Class error status
  localparam logic [7:0] SW2_BAD_CLA   = 8'h00;
  // Family identifier wildcard
  localparam logic [7:0] AFI_ALL       = 8'h00;
  localparam logic [3:0] NIB_ZERO      = 4'h0;
  // Controller states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,   // Deselected, waiting for activation
    ST_READY = 2'b01,   // Active, waiting for a block
    ST_APP   = 2'b10    // Waiting for the application reply
  } cbp_state_t;
  // Kind of outgoing block
  typedef enum logic [2:0] {
    TX_NONE  = 3'b000,
    TX_I     = 3'b001,
    TX_R_ACK = 3'b010,
    TX_S_DES = 3'b011,
    TX_CLA   = 3'b100
  } cbp_tx_t;
endpackage

// ===== design/cbp_afi_match.sv
// Purpose: Decide whether a family request addresses this transponder
// Assumes: Stored family value is stable while a request is judged
// Notes:   Purely combinational; the top registers the verdict
`timescale 1ns/1ps
`default_nettype none
module cbp_afi_match (
  input  wire logic [7:0] req_afi,     // Family value from the request
  input  wire logic [7:0] own_afi,     // Stored family value
  output logic            match        // Request addresses us
);
  logic hi_wild;  // Form 0xY0
  logic lo_wild;  // Form 0x0Y

  // Wildcard forms compare one nibble only
  always_comb
  begin
    hi_wild = (req_afi[3:0] == cbp_pkg::NIB_ZERO) && (req_afi[7:4] != cbp_pkg::NIB_ZERO);
    lo_wild = (req_afi[7:4] == cbp_pkg::NIB_ZERO) && (req_afi[3:0] != cbp_pkg::NIB_ZERO);
    if (req_afi == cbp_pkg::AFI_ALL)
      match = 1'b1;
    else if (hi_wild)
      match = (req_afi[7:4] == own_afi[7:4]);
    else if (lo_wild)
      match = (req_afi[3:0] == own_afi[3:0]);
    else
      match = (req_afi == own_afi);
  end
endmodule
`default_nettype wire

// ===== design/cbp_ctrl.sv
// Purpose: Transponder-side block protocol controller (numbering, chaining, retransmit)
// Assumes: Frames arrive deframed; one strobe per received block with its control byte
// Notes:   Reply payload bytes live in the application; this block picks the block kind
`timescale 1ns/1ps
`default_nettype none
module cbp_ctrl (
  input  wire logic       mclk,          // Core clock, 10 MHz
  input  wire logic       rst_b,         // Asynchronous reset, active low
  input  wire logic       activate,      // Pulse: transponder activated
  input  wire logic       reqb_valid,    // Pulse: family request received
  input  wire logic [7:0] reqb_afi,      // Family value of the request
  input  wire logic [7:0] own_afi,       // Stored family value
  input  wire logic       rx_valid,      // Pulse: block received
  input  wire logic [7:0] rx_pcb,        // Control byte of that block
  input  wire logic [7:0] rx_cla,        // First payload byte (class)
  input  wire logic       rx_bad,        // Block malformed
  input  wire logic       app_done,      // Pulse: application reply ready
  input  wire logic       app_chain,     // Reply continues in another block
  output logic            reqb_answer,   // Pulse: send request answer
  output logic            app_start,     // Pulse: pass command to application
  output logic            app_next,      // Pulse: application advances reply
  output logic            tx_valid,      // Pulse: send a block
  output logic [7:0]      tx_pcb,        // Control byte of that block
  output logic            tx_resend,     // Block repeats the kept I-block
  output logic            tx_status,     // Block carries the class error status
  output logic [15:0]     tx_sw,         // Status word for class error
  output logic            active,        // Protocol active
  output logic            deselected     // Pulse: left the protocol
);
  cbp_pkg::cbp_state_t st_q, st_d;     // Controller state
  logic       bn_q, bn_d;              // Own block number
  logic       chain_q, chain_d;        // We are sending a chained reply
  logic       kept_q, kept_d;          // Last I-block held for retransmit
  logic [7:0] last_q, last_d;          // Control byte of the kept I-block
  logic       txv_q, txv_d;
  logic [7:0] txp_q, txp_d;
  logic       rs_q, rs_d;
  logic       ts_q, ts_d;
  logic       ra_q, ra_d;
  logic       as_q, as_d;
  logic       an_q, an_d;
  logic       ds_q, ds_d;
  logic       act_q, act_d;            // Protocol active, registered for the port
  logic       afi_hit;                 // Family request addresses us
  logic [1:0] rtype;                   // Received block type
  logic       rbn;                     // Received block number
  logic       ill;                     // Illegal prologue

  cbp_afi_match u_afi (
    .req_afi (reqb_afi),
    .own_afi (own_afi),
    .match   (afi_hit)
  );

  // Decode of the incoming control byte
  always_comb
  begin
    rtype = rx_pcb[7:6];
    rbn   = rx_pcb[cbp_pkg::PCB_BN_BIT];
    // Identifier fields are unsupported, so such a block is dropped
    ill   = rx_bad || rx_pcb[cbp_pkg::PCB_CID_BIT]
          || (rtype == cbp_pkg::PCB_TYPE_I && rx_pcb[cbp_pkg::PCB_NAD_BIT]);
  end

  // Next-state logic; only the reader opens an exchange, we only answer
  always_comb
  begin
    st_d    = st_q;
    bn_d    = bn_q;
    chain_d = chain_q;
    kept_d  = kept_q;
    last_d  = last_q;
    txv_d   = 1'b0;
    txp_d   = txp_q;
    rs_d    = 1'b0;
    ts_d    = 1'b0;
    ra_d    = 1'b0;
    as_d    = 1'b0;
    an_d    = 1'b0;
    ds_d    = 1'b0;
    // Family request is judged in any state
    if (reqb_valid && afi_hit)
      ra_d = 1'b1;
    if (activate)
    begin
      st_d    = cbp_pkg::ST_READY;
      bn_d    = cbp_pkg::BN_RESET;
      chain_d = 1'b0;
      kept_d  = 1'b0;
    end
    else
    begin
      case (st_q)
        cbp_pkg::ST_IDLE:
        begin
          st_d = cbp_pkg::ST_IDLE;     // Silent until activated
        end
        cbp_pkg::ST_READY:
        begin
          if (rx_valid && !ill)
          begin
            case (rtype)
              cbp_pkg::PCB_TYPE_I:
              begin
                bn_d   = ~bn_q;
                kept_d = 1'b0;         // New command acknowledges our last I
                if (rx_pcb[cbp_pkg::PCB_CHAIN_BIT])
                begin
                  txv_d = 1'b1;
                  txp_d = cbp_pkg::PCB_R_ACK | {7'h00, ~bn_q};
                end
                else if (rx_cla != cbp_pkg::CLA_ONLY)
                begin
                  txv_d  = 1'b1;
                  ts_d   = 1'b1;
                  txp_d  = cbp_pkg::PCB_I_BASE | {7'h00, ~bn_q};
                  kept_d = 1'b1;
                  last_d = cbp_pkg::PCB_I_BASE | {7'h00, ~bn_q};
                end
                else
                begin
                  as_d = 1'b1;
                  st_d = cbp_pkg::ST_APP;
                end
              end
              cbp_pkg::PCB_TYPE_R:
              begin
                if (rbn == bn_q)
                begin
                  // Repeat of our kept I-block, if one is kept; number unchanged
                  if (kept_q)
                  begin
                    txv_d = 1'b1;
                    rs_d  = 1'b1;
                    txp_d = last_q;
                  end
                end
                else if (rx_pcb[cbp_pkg::PCB_NAK_BIT])
                begin
                  txv_d = 1'b1;
                  txp_d = cbp_pkg::PCB_R_ACK | {7'h00, bn_q};
                end
                else
                begin
                  bn_d   = ~bn_q;
                  kept_d = 1'b0;
                  if (chain_q)
                  begin
                    an_d = 1'b1;
                    st_d = cbp_pkg::ST_APP;
                  end
                end
              end
              cbp_pkg::PCB_TYPE_S:
              begin
                // Only DESELECT is known; other S requests are ignored
                if (rx_pcb[5:4] == cbp_pkg::S_KIND_DESEL)
                begin
                  txv_d = 1'b1;
                  txp_d = cbp_pkg::PCB_S_DESEL;
                  ds_d  = 1'b1;
                  st_d  = cbp_pkg::ST_IDLE;
                end
              end
              default:
              begin
                st_d = cbp_pkg::ST_READY;
              end
            endcase
          end
        end
        cbp_pkg::ST_APP:
        begin
          // The reply is always an I-block, never a wait extension
          if (app_done)
          begin
            txv_d   = 1'b1;
            txp_d   = cbp_pkg::PCB_I_BASE | {3'h0, app_chain, 3'h0, bn_q};
            chain_d = app_chain;
            kept_d  = 1'b1;
            last_d  = cbp_pkg::PCB_I_BASE | {3'h0, app_chain, 3'h0, bn_q};
            st_d    = cbp_pkg::ST_READY;
          end
        end
        default:
        begin
          st_d = cbp_pkg::ST_IDLE;
        end
      endcase
    end
    // Flag follows the next state so the port comes straight from a flop
    act_d = (st_d != cbp_pkg::ST_IDLE);
  end

  // State registers
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q    <= cbp_pkg::ST_IDLE;
      bn_q    <= cbp_pkg::BN_RESET;
      chain_q <= 1'b0;
      kept_q  <= 1'b0;
      last_q  <= 8'h00;
      txv_q   <= 1'b0;
      txp_q   <= 8'h00;
      rs_q    <= 1'b0;
      ts_q    <= 1'b0;
      ra_q    <= 1'b0;
      as_q    <= 1'b0;
      an_q    <= 1'b0;
      ds_q    <= 1'b0;
      act_q   <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      bn_q    <= bn_d;
      chain_q <= chain_d;
      kept_q  <= kept_d;
      last_q  <= last_d;
      txv_q   <= txv_d;
      txp_q   <= txp_d;
      rs_q    <= rs_d;
      ts_q    <= ts_d;
      ra_q    <= ra_d;
      as_q    <= as_d;
      an_q    <= an_d;
      ds_q    <= ds_d;
      act_q   <= act_d;
    end
  end

  // Outputs straight from flip-flops, except tx_sw which is a constant
  always_comb
  begin
    tx_valid    = txv_q;
    tx_pcb      = txp_q;
    tx_resend   = rs_q;
    tx_status   = ts_q;
    tx_sw       = {cbp_pkg::SW1_BAD_CLA, cbp_pkg::SW2_BAD_CLA};
    reqb_answer = ra_q;
    app_start   = as_q;
    app_next    = an_q;
    active      = act_q;
    deselected  = ds_q;
  end
endmodule
`default_nettype wire

// ===== bench/cbp_ctrl_properties.sv
// Purpose: Port assertions for the block protocol controller
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound onto every cbp_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module cbp_ctrl_properties (
  input wire logic        mclk,        // Core clock
  input wire logic        rst_b,       // Reset, active low
  input wire logic        activate,    // Activation pulse
  input wire logic        reqb_valid,  // Family request strobe
  input wire logic [7:0]  reqb_afi,    // Requested family
  input wire logic [7:0]  own_afi,     // Stored family
  input wire logic        rx_valid,    // Block strobe
  input wire logic [7:0]  rx_pcb,      // Received control byte
  input wire logic [7:0]  rx_cla,      // Received class byte
  input wire logic        reqb_answer, // Request answer pulse
  input wire logic        app_start,   // Command handed over
  input wire logic        tx_valid,    // Block sent
  input wire logic [7:0]  tx_pcb,      // Sent control byte
  input wire logic        tx_resend,   // Repeat of kept block
  input wire logic        tx_status,   // Class error reply
  input wire logic [15:0] tx_sw,       // Status word
  input wire logic        active,      // Protocol active
  input wire logic        deselected   // Deselect pulse
);
  // One domain, so clock and disable are shared
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_desel_pair: assert property (deselected |-> tx_valid && tx_pcb == 8'hc2 && !active)
    else $error("deselect reply malformed");
  a_desel_cause: assert property (deselected |-> $past(rx_valid && rx_pcb == 8'hc2))
    else $error("deselect without request");
  a_no_wtx: assert property (tx_valid |-> tx_pcb[7:6] != 2'h3 || tx_pcb == 8'hc2)
    else $error("unsupported supervisory block sent");
  a_cla_status: assert property (tx_status |-> tx_valid && tx_sw == 16'h6e00)
    else $error("class error status wrong");
  a_start_cause: assert property (app_start |->
    $past(rx_valid && rx_pcb[7:6] == 2'h0 && !rx_pcb[4] && rx_cla == 8'h00))
    else $error("command start without plain block");
  a_afi_all: assert property (reqb_valid && reqb_afi == 8'h00 |=> reqb_answer)
    else $error("family zero not answered");
  a_afi_full: assert property (reqb_valid && reqb_afi == own_afi |=> reqb_answer)
    else $error("exact family not answered");
  a_answer_cause: assert property (reqb_answer |-> $past(reqb_valid))
    else $error("answer without request");
  a_resend_kind: assert property (tx_resend |-> tx_valid && tx_pcb[7:6] == 2'h0)
    else $error("resend is not an I-block");
  a_act_cause: assert property ($rose(active) |-> $past(activate))
    else $error("active without activation");
  a_afi_upper: assert property (reqb_valid && reqb_afi[3:0] == 4'h0 && reqb_afi[7:4] != 4'h0
    && reqb_afi[7:4] == own_afi[7:4] |=> reqb_answer)
    else $error("upper nibble family not answered");
  a_afi_lower: assert property (reqb_valid && reqb_afi[7:4] == 4'h0 && reqb_afi[3:0] != 4'h0
    && reqb_afi[3:0] == own_afi[3:0] |=> reqb_answer)
    else $error("lower nibble family not answered");
  a_afi_refuse: assert property (reqb_valid && reqb_afi[7:4] != 4'h0 && reqb_afi[3:0] != 4'h0
    && reqb_afi != own_afi |=> !reqb_answer)
    else $error("foreign family answered");
endmodule
bind cbp_ctrl cbp_ctrl_properties chk_i (.mclk, .rst_b, .activate, .reqb_valid, .reqb_afi,
  .own_afi, .rx_valid, .rx_pcb, .rx_cla, .reqb_answer, .app_start, .tx_valid, .tx_pcb,
  .tx_resend, .tx_status, .tx_sw, .active, .deselected);
`default_nettype wire

// ===== bench/cbp_rw_model.sv
// Purpose: Reader/writer model facing the controller
// Assumes: Blocks are sent only when the bench asks
// Notes:   Released qualifiers show the inverse so stale values cannot pass
`timescale 1ns/1ps
`default_nettype none
module cbp_rw_model (
  input  wire logic       mclk,     // Core clock
  input  wire logic       activate, // Activation pulse
  input  wire logic       tx_valid, // Controller block strobe
  input  wire logic [7:0] tx_pcb,   // Controller control byte
  output var  logic       rx_valid, // Block strobe to controller
  output var  logic [7:0] rx_pcb,   // Control byte
  output var  logic [7:0] rx_cla,   // Class byte
  output var  logic       rx_bad    // Malformed mark
);
  logic rbn = 1'h0; // Reader block number
  initial
  begin
    rx_valid = 1'h0;
    rx_pcb = 8'h00;
    rx_cla = 8'h00;
    rx_bad = 1'h0;
  end
  // Numbering follows every I or ACK that carries our number; counted on the
  // falling edge so a block driven at the next rising edge already sees it
  always @(negedge mclk)
  begin
    if (activate)
      rbn <= 1'h0;
    else if (tx_valid && (tx_pcb[7:6] == 2'h0 || tx_pcb[7:4] == 4'ha) && tx_pcb[0] == rbn)
      rbn <= ~rbn;
  end
  // Reader always opens an exchange; one block per strobe
  task automatic send(input logic [7:0] pcb, input logic [7:0] cla, input logic bad);
    @(posedge mclk);
    put(pcb, cla, bad);
  endtask
  // Block number filled in at the driving edge, after the last reply was counted
  task automatic send_cur(input logic [6:0] hi, input logic [7:0] cla, input logic bad);
    @(posedge mclk);
    put({hi, rbn}, cla, bad);
  endtask
  // Strobe for one cycle, then show the inverse so stale qualifiers cannot pass
  task automatic put(input logic [7:0] pcb, input logic [7:0] cla, input logic bad);
    rx_valid <= 1'h1;
    rx_pcb <= pcb;
    rx_cla <= cla;
    rx_bad <= bad;
    @(posedge mclk);
    rx_valid <= 1'h0;
    rx_pcb <= ~pcb;
    rx_cla <= ~cla;
    rx_bad <= ~bad;
    #1;
  endtask
endmodule
`default_nettype wire

// ===== bench/contactless_block_protocol_ctrl_tb.sv
// Purpose: Self-checking bench for the block protocol controller
// Assumes: Outputs land at the taking edge, one cycle after the driving edge
// Notes:   Expected block numbers are tracked by hand per scenario
`timescale 1ns/1ps
`default_nettype none
module contactless_block_protocol_ctrl_tb;
  logic        mclk = 1'h0;       // Core clock, 100 ns
  logic        rst_b = 1'h0;      // Reset, active low
  logic        activate = 1'h0;   // Activation pulse
  logic        reqb_valid = 1'h0; // Family request strobe
  logic [7:0]  reqb_afi = 8'h00;  // Requested family
  logic [7:0]  own_afi = 8'h35;   // Stored family, both nibbles nonzero
  logic        app_done = 1'h0;   // Application reply strobe
  logic        app_chain = 1'h0;  // Reply continues
  logic        rx_valid, rx_bad, reqb_answer, app_start, app_next, tx_valid;
  logic        tx_resend, tx_status, active, deselected;
  logic [7:0]  rx_pcb, rx_cla, tx_pcb;
  logic [15:0] tx_sw;
  int          num_errors = 0;    // Mismatches
  int          n_checks = 0;      // Comparisons
  logic [7:0]  afi_tbl [8] = '{8'h00, 8'h30, 8'h05, 8'h35, 8'h40, 8'h06, 8'h36, 8'h53};
  always #50 mclk = ~mclk;
  cbp_ctrl uut (.mclk, .rst_b, .activate, .reqb_valid, .reqb_afi, .own_afi, .rx_valid,
    .rx_pcb, .rx_cla, .rx_bad, .app_done, .app_chain, .reqb_answer, .app_start, .app_next,
    .tx_valid, .tx_pcb, .tx_resend, .tx_status, .tx_sw, .active, .deselected);
  cbp_rw_model rw (.mclk, .activate, .tx_valid, .tx_pcb, .rx_valid, .rx_pcb, .rx_cla, .rx_bad);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Block sent this cycle: strobe, resend, status and control byte
  task automatic txe(input logic [7:0] pcb, input logic rs, input logic st);
    chk({5'h0, tx_valid, tx_resend, tx_status, tx_pcb}, {5'h1, rs, st, pcb});
  endtask
  task automatic quiet;
    chk({14'h0, tx_valid, app_start}, 16'h0);
  endtask
  task automatic app(input logic chain);
    @(posedge mclk);
    app_done <= 1'h1;
    app_chain <= chain;
    @(posedge mclk);
    app_done <= 1'h0;
    app_chain <= ~chain;
    #1;
  endtask
  task automatic t_numbers;
    @(posedge mclk);
    activate <= 1'h1;
    @(posedge mclk);
    activate <= 1'h0;
    rw.send(8'hb2, 8'h00, 1'h0);
    txe(8'ha3, 1'h0, 1'h0);
    rw.send_cur(7'h01, 8'h00, 1'h0);
    chk({15'h0, app_start}, 16'h1);
    app(1'h0);
    txe(8'h02, 1'h0, 1'h0);
  endtask
  task automatic t_retx;
    rw.send(8'hb2, 8'h00, 1'h0);
    txe(8'h02, 1'h1, 1'h0);
    rw.send(8'ha2, 8'h00, 1'h0);
    txe(8'h02, 1'h1, 1'h0);
    rw.send(8'hb3, 8'h00, 1'h0);
    txe(8'ha2, 1'h0, 1'h0);
    rw.send(8'hb2, 8'h00, 1'h0);
    txe(8'h02, 1'h1, 1'h0);
  endtask
  task automatic t_class;
    rw.send_cur(7'h01, 8'h5a, 1'h0);
    txe(8'h03, 1'h0, 1'h1);
    chk(tx_sw, 16'h6e00);
    chk({15'h0, app_start}, 16'h0);
  endtask
  task automatic t_chain;
    rw.send_cur(7'h09, 8'h00, 1'h0);
    txe(8'ha2, 1'h0, 1'h0);
    rw.send_cur(7'h01, 8'h00, 1'h0);
    chk({15'h0, app_start}, 16'h1);
    app(1'h1);
    txe(8'h13, 1'h0, 1'h0);
    // Reader missed the chained block, so it acks with its old number
    rw.send(8'ha3, 8'h00, 1'h0);
    txe(8'h13, 1'h1, 1'h0);
    rw.send(8'ha2, 8'h00, 1'h0);
    chk({15'h0, app_next}, 16'h1);
    app(1'h0);
    txe(8'h02, 1'h0, 1'h0);
  endtask
  task automatic t_refuse;
    rw.send_cur(7'h01, 8'h00, 1'h1);
    quiet();
    rw.send(8'h0b, 8'h00, 1'h0);
    quiet();
    rw.send(8'hb2, 8'h00, 1'h0);
    txe(8'h02, 1'h1, 1'h0);
  endtask
  task automatic t_desel;
    rw.send(8'hc2, 8'h00, 1'h0);
    chk({5'h0, tx_valid, deselected, active, tx_pcb}, {5'h0, 3'b110, 8'hc2});
    rw.send_cur(7'h01, 8'h00, 1'h0);
    quiet();
  endtask
  task automatic t_afi;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      reqb_valid <= 1'h1;
      reqb_afi <= afi_tbl[i];
      @(posedge mclk);
      reqb_valid <= 1'h0;
      reqb_afi <= ~afi_tbl[i];
      #1;
      chk({15'h0, reqb_answer}, {15'h0, i < 4});
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial
  begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'h1;
    t_numbers();
    t_retx();
    t_class();
    t_chain();
    t_refuse();
    t_desel();
    t_afi();
    conclude();
  end
endmodule
`default_nettype wire
